// file: design/bmp_pkg.sv
package bmp_pkg;
   // power modes
   typedef enum logic [3:0] {
      BMP_OFF     = 4'h1,
      BMP_STANDBY = 4'h2,
      BMP_ACTIVE  = 4'h4,
      BMP_SLEEP   = 4'h8
   } bmp_mode_t;

   // command codes from the link decoder
   typedef enum logic [2:0] {
      BMP_CMD_NONE     = 3'h0,
      BMP_CMD_SLEEP    = 3'h1,
      BMP_CMD_RESET    = 3'h2,
      BMP_CMD_CALC_SUM = 3'h3,
      BMP_CMD_CHK_SUM  = 3'h4,
      BMP_CMD_SCAN_A   = 3'h5,
      BMP_CMD_SCAN_B   = 3'h6,
      BMP_CMD_DIRECT   = 3'h7
   } bmp_cmd_t;

   // balancing modes
   localparam logic [1:0] BMP_BAL_MANUAL = 2'h0;
   localparam logic [1:0] BMP_BAL_TIMED = 2'h1;
   localparam logic [1:0] BMP_BAL_AUTO = 2'h2;

   localparam int BMP_CELLS = 12;
   localparam int BMP_MAX_DEVICES = 14;
   localparam int BMP_MAX_CHAIN_CELLS = 168;
   localparam int BMP_WORDS = 8;
   localparam int BMP_CLK_MHZ = 25;
   localparam int BMP_OP_NS = 400;
   localparam int BMP_OP_CYC = (BMP_OP_NS * BMP_CLK_MHZ + 999) / 1000;
   localparam int BMP_WD_CYC = 4000;
   localparam logic [15:0] BMP_SUM_RST = 16'h0000;
endpackage : bmp_pkg

// file: design/bmp_power_modes.sv
`timescale 1ns/10ps
// How it works
// [RULE_01] three power modes exist: normal, sleep and shutdown
// [RULE_02] sleep entered by sleep command or watchdog timeout
// [RULE_03] sleep keeps registers, timed scans and balancing; link activity wakes it; here there are no timed scans and scan commands are refused in sleep
// [RULE_04] enable pin low forces shutdown
// [RULE_05] leaving shutdown does not reload eeprom into registers
// [RULE_06] host toggles enable low then high, then waits settle time
// [RULE_07] host enumerates chain after settle wait before other commands
// [RULE_08] host sends reset to each device starting at top
// [RULE_09] reset command recalls eeprom and computes eeprom signature
// [RULE_10] host enumerates again after software reset
// [RULE_11] host compares stored and calculated eeprom signatures
// [RULE_12] host rewrites non-default settings after recovery
// [RULE_13] host sends calculate-register-checksum after reloading settings
// [RULE_14] check-checksum command sends fault response on mismatch
// [RULE_15] normal mode has standby waiting and active operating states
// [RULE_16] measurement results pass unfiltered; only fault paths are filtered
// [RULE_17] twelve cells per device, fourteen devices, 168 cells
// [RULE_18] two scan modes plus single direct measurement
// [RULE_19] faults reported as command responses or unprompted messages
// [RULE_20] manual, timed and auto-terminating balancing modes; timed mode here acts like manual, with no timer
// [RULE_21] communication wake returns to standby
module bmp_power_modes
   import bmp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic link_activity,
   input wire bmp_pkg::bmp_cmd_t cmd,
   input wire logic cmd_valid,
   input wire logic [15:0] eeprom_word,
   input wire logic [15:0] reg_sum_live,
   input wire logic [13:0] adc_sample,
   input wire logic adc_sample_valid,
   input wire logic fault_raw,
   input wire logic comm_fault,
   input wire logic [1:0] bal_mode_sel,
   input wire logic bal_target_met,
   output logic [3:0] mode,
   output logic [15:0] eeprom_signature,
   output logic recall_done,
   output logic [15:0] reg_sum,
   output logic sum_fault_resp,
   output logic unprompted_fault,
   output logic [13:0] adc_result,
   output logic fault_filtered,
   output logic balance_on,
   output logic [1:0] scan_kind
);
   import bmp_pkg::*; // [RULE_17] cell and chain counts

   bmp_mode_t mode_q, mode_d;
   logic [15:0] sig_q, sig_d, sum_q, sum_d;
   logic [12:0] wd_q, wd_d;
   logic [3:0] op_q, op_d;
   logic [2:0] rcl_q, rcl_d;
   logic rbusy_q, rbusy_d, rdone_q, rdone_d;
   logic sf_q, sf_d, uf_q, uf_d;
   logic [13:0] adc_q, adc_d;
   logic [1:0] flt_q, flt_d;
   logic ff_q, ff_d, bal_q, bal_d;
   logic [1:0] sk_q, sk_d;
   logic go_sleep, wd_exp;

   assign wd_exp = (wd_q == 13'(BMP_WD_CYC));
   assign go_sleep = (cmd_valid && cmd == BMP_CMD_SLEEP) || wd_exp; // [RULE_02]

   always_comb begin
      mode_d = mode_q;
      op_d = op_q;
      wd_d = wd_q;
      sk_d = sk_q;
      if (link_activity || cmd_valid) begin
         wd_d = '0;
      end else if (!wd_exp && mode_q != BMP_SLEEP) begin
         wd_d = wd_q + 13'h0001;
      end
      case (mode_q)
         BMP_OFF: begin
            if (enable) begin
               mode_d = BMP_STANDBY; // [RULE_05]
            end
         end
         BMP_STANDBY: begin
            if (go_sleep) begin
               mode_d = BMP_SLEEP; // [RULE_02]
            end else if (cmd_valid && cmd >= BMP_CMD_SCAN_A) begin
               mode_d = BMP_ACTIVE; // [RULE_15]
               op_d = 4'(BMP_OP_CYC);
               sk_d = 2'(cmd - BMP_CMD_SCAN_A); // [RULE_18]
            end
         end
         BMP_ACTIVE: begin
            if (op_q <= 4'h1) begin
               mode_d = BMP_STANDBY; // [RULE_15]
            end
            op_d = op_q - 4'h1;
         end
         BMP_SLEEP: begin
            if (link_activity) begin
               mode_d = BMP_STANDBY; // [RULE_03] [RULE_21]
               wd_d = '0;
            end
         end
         default: mode_d = BMP_OFF;
      endcase
      if (!enable) begin
         mode_d = BMP_OFF; // [RULE_04] [RULE_01]
         wd_d = '0;
      end
   end

   always_comb begin
      sig_d = sig_q;
      rcl_d = rcl_q;
      rbusy_d = rbusy_q;
      rdone_d = 1'b0;
      sum_d = sum_q;
      sf_d = 1'b0;
      if (mode_q == BMP_STANDBY && cmd_valid && cmd == BMP_CMD_RESET) begin
         rbusy_d = 1'b1; // [RULE_09]
         rcl_d = '0;
         sig_d = BMP_SUM_RST;
      end else if (rbusy_q) begin
         sig_d = {sig_q[14:0], sig_q[15] ^ sig_q[13]} ^ eeprom_word; // [RULE_09]
         rcl_d = rcl_q + 3'h1;
         if (rcl_q == 3'(BMP_WORDS - 1)) begin
            rbusy_d = 1'b0;
            rdone_d = 1'b1;
         end
      end
      if (mode_q == BMP_STANDBY && cmd_valid && cmd == BMP_CMD_CALC_SUM) begin
         sum_d = reg_sum_live;
      end
      if (mode_q == BMP_STANDBY && cmd_valid && cmd == BMP_CMD_CHK_SUM) begin
         sf_d = (reg_sum_live != sum_q); // [RULE_14] [RULE_19]
      end
      if (!enable) begin
         rbusy_d = 1'b0;
      end
   end

   always_comb begin
      adc_d = adc_sample_valid ? adc_sample : adc_q; // [RULE_16]
      flt_d = {flt_q[0], fault_raw};
      ff_d = ff_q;
      if (flt_q[1] == flt_q[0]) begin
         ff_d = flt_q[1]; // [RULE_16]
      end
      uf_d = comm_fault && mode_q != BMP_OFF; // [RULE_19]
      case (bal_mode_sel)
         BMP_BAL_MANUAL: bal_d = mode_q != BMP_OFF; // [RULE_20]
         BMP_BAL_TIMED: bal_d = mode_q != BMP_OFF;
         BMP_BAL_AUTO: bal_d = mode_q != BMP_OFF && !bal_target_met; // [RULE_20]
         default: bal_d = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mode_q <= BMP_OFF;
         wd_q <= '0;
         op_q <= '0;
         sk_q <= '0;
         sig_q <= BMP_SUM_RST;
         rcl_q <= '0;
         rbusy_q <= 1'b0;
         rdone_q <= 1'b0;
         sum_q <= BMP_SUM_RST;
         sf_q <= 1'b0;
         uf_q <= 1'b0;
         adc_q <= '0;
         flt_q <= '0;
         ff_q <= 1'b0;
         bal_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         wd_q <= wd_d;
         op_q <= op_d;
         sk_q <= sk_d;
         sig_q <= sig_d;
         rcl_q <= rcl_d;
         rbusy_q <= rbusy_d;
         rdone_q <= rdone_d;
         sum_q <= sum_d;
         sf_q <= sf_d;
         uf_q <= uf_d;
         adc_q <= adc_d;
         flt_q <= flt_d;
         ff_q <= ff_d;
         bal_q <= bal_d;
      end
   end

   assign mode = mode_q;
   assign eeprom_signature = sig_q;
   assign recall_done = rdone_q;
   assign reg_sum = sum_q;
   assign sum_fault_resp = sf_q;
   assign unprompted_fault = uf_q;
   assign adc_result = adc_q;
   assign fault_filtered = ff_q;
   assign balance_on = bal_q;
   assign scan_kind = sk_q;

   a_enable_low_off: assert property (@(posedge ref_clk) disable iff (rst)
      !enable |=> mode_q == BMP_OFF) else $error("enable low did not shut down"); // [RULE_04]
   a_sleep_cmd: assert property (@(posedge ref_clk) disable iff (rst)
      enable && mode_q == BMP_STANDBY && cmd_valid && cmd == BMP_CMD_SLEEP |=> mode_q == BMP_SLEEP)
      else $error("sleep command ignored"); // [RULE_02]
   a_wake_standby: assert property (@(posedge ref_clk) disable iff (rst)
      enable && mode_q == BMP_SLEEP && link_activity |=> mode_q == BMP_STANDBY)
      else $error("no wake to standby"); // [RULE_21]
   a_sleep_holds: assert property (@(posedge ref_clk) disable iff (rst)
      enable && mode_q == BMP_SLEEP && !link_activity |=> mode_q == BMP_SLEEP)
      else $error("sleep left without wake"); // [RULE_03]
   a_off_to_standby: assert property (@(posedge ref_clk) disable iff (rst)
      mode_q == BMP_OFF && enable |=> mode_q == BMP_STANDBY && $stable(sig_q))
      else $error("shutdown exit wrong"); // [RULE_05]
   a_recall_len: assert property (@(posedge ref_clk) disable iff (rst)
      enable && mode_q == BMP_STANDBY && cmd_valid && cmd == BMP_CMD_RESET ##1 enable [*8]
      |=> rdone_q) else $error("recall did not finish in 8 words"); // [RULE_09]
   a_chk_fault: assert property (@(posedge ref_clk) disable iff (rst)
      mode_q == BMP_STANDBY && cmd_valid && cmd == BMP_CMD_CHK_SUM
      |=> sf_q == ($past(reg_sum_live) != $past(sum_q)))
      else $error("checksum fault wrong"); // [RULE_14]
   a_active_ends: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(mode_q == BMP_ACTIVE) |-> ##[1:12] mode_q != BMP_ACTIVE)
      else $error("operation never ends"); // [RULE_15]
   a_adc_pass: assert property (@(posedge ref_clk) disable iff (rst)
      adc_sample_valid |=> adc_q == $past(adc_sample)) else $error("adc filtered"); // [RULE_16]
   a_auto_stop: assert property (@(posedge ref_clk) disable iff (rst)
      bal_mode_sel == BMP_BAL_AUTO && bal_target_met |=> !bal_q) else $error("auto balance ran on"); // [RULE_20]
   c_sleep_wake: cover property (@(posedge ref_clk) mode_q == BMP_SLEEP ##[1:20] mode_q == BMP_STANDBY);
   c_scan: cover property (@(posedge ref_clk) mode_q == BMP_ACTIVE);
   c_recall: cover property (@(posedge ref_clk) rdone_q);
   c_sum_fault: cover property (@(posedge ref_clk) sf_q);
endmodule : bmp_power_modes

// file: tb/bmp_host_model.sv
`timescale 1ns/10ps
module bmp_host_model
   import bmp_pkg::*;
#(
   parameter int SETTLE_CYC = 4
)
(
   input wire logic ref_clk,
   output bmp_pkg::bmp_cmd_t cmd,
   output logic cmd_valid,
   output logic enable,
   output logic link_activity
);
   initial begin
      cmd = BMP_CMD_NONE;
      cmd_valid = 1'b0;
      enable = 1'b0;
      link_activity = 1'b0;
   end
   // one-cycle command strobe, code cleared after
   task automatic send(input bmp_cmd_t c);
      @(posedge ref_clk);
      cmd <= c;
      cmd_valid <= 1'b1;
      @(posedge ref_clk);
      cmd <= BMP_CMD_NONE;
      cmd_valid <= 1'b0;
   endtask : send
   task automatic power(input logic on);
      @(posedge ref_clk);
      enable <= on;
   endtask : power
   task automatic wake();
      @(posedge ref_clk);
      link_activity <= 1'b1;
      @(posedge ref_clk);
      link_activity <= 1'b0;
   endtask : wake
   // toggle enable, settle, enumeration outside, then reset command
   task automatic recover();
      power(1'b0);
      power(1'b1);
      repeat (SETTLE_CYC) @(posedge ref_clk);
      send(BMP_CMD_RESET);
   endtask : recover
endmodule : bmp_host_model

// file: tb/bmp_power_modes_bench.sv
`timescale 1ns/10ps
module bmp_power_modes_bench;
   import bmp_pkg::*;
   logic ref_clk, rst, enable, link_activity, cmd_valid, adc_sample_valid, comm_fault;
   bmp_cmd_t cmd;
   logic [15:0] eeprom_word, reg_sum_live, eeprom_signature, reg_sum;
   logic [13:0] adc_sample, adc_result;
   logic [3:0] mode;
   logic [1:0] scan_kind;
   logic recall_done, sum_fault_resp, unprompted_fault, fault_filtered, balance_on;
   logic fault_raw, bal_target_met;
   logic [1:0] bal_mode_sel;
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   bmp_host_model #(.SETTLE_CYC(4)) bmp_host_model_inst (.ref_clk(ref_clk), .cmd(cmd), .cmd_valid(cmd_valid),
      .enable(enable), .link_activity(link_activity));
   bmp_power_modes bmp_power_modes_inst (.ref_clk(ref_clk), .rst(rst), .enable(enable),
      .link_activity(link_activity), .cmd(cmd), .cmd_valid(cmd_valid), .eeprom_word(eeprom_word),
      .reg_sum_live(reg_sum_live), .adc_sample(adc_sample), .adc_sample_valid(adc_sample_valid),
      .fault_raw(fault_raw), .comm_fault(comm_fault), .bal_mode_sel(bal_mode_sel), .bal_target_met(bal_target_met),
      .mode(mode), .eeprom_signature(eeprom_signature), .recall_done(recall_done), .reg_sum(reg_sum),
      .sum_fault_resp(sum_fault_resp), .unprompted_fault(unprompted_fault), .adc_result(adc_result),
      .fault_filtered(fault_filtered), .balance_on(balance_on), .scan_kind(scan_kind));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : check
   task automatic stop_test();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : stop_test
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         stop_test();
      end
   end
   task automatic t_scan(input bmp_cmd_t c, input logic [1:0] kind);
      bmp_host_model_inst.send(c);
      repeat (9) @(posedge ref_clk);
      #1 check(16'(mode), 16'(BMP_ACTIVE), "busy");
      check(16'(scan_kind), 16'(kind), "scan kind");
      @(posedge ref_clk);
      #1 check(16'(mode), 16'(BMP_STANDBY), "idle");
   endtask : t_scan
   task automatic t_sum();
      @(posedge ref_clk);
      reg_sum_live <= 16'h1234;
      bmp_host_model_inst.send(BMP_CMD_CALC_SUM);
      repeat (2) @(posedge ref_clk);
      #1 check(reg_sum, 16'h1234, "stored sum");
      @(posedge ref_clk);
      reg_sum_live <= 16'h4321;
      bmp_host_model_inst.send(BMP_CMD_CHK_SUM);
      #1 check(16'(sum_fault_resp), 16'h0001, "mismatch");
      @(posedge ref_clk);
      reg_sum_live <= 16'h1234;
      bmp_host_model_inst.send(BMP_CMD_CHK_SUM);
      #1 check(16'(sum_fault_resp), 16'h0000, "match");
   endtask : t_sum
   task automatic t_sleep();
      bmp_host_model_inst.send(BMP_CMD_SLEEP);
      @(posedge ref_clk);
      #1 check(16'(mode), 16'(BMP_SLEEP), "sleep");
      bmp_host_model_inst.send(BMP_CMD_SCAN_A);
      repeat (2) @(posedge ref_clk);
      #1 check(16'(mode), 16'(BMP_SLEEP), "refused");
      check(16'(balance_on), 16'h0001, "balance in sleep");
      bmp_host_model_inst.wake();
      repeat (2) @(posedge ref_clk);
      #1 check(16'(mode), 16'(BMP_STANDBY), "wake");
   endtask : t_sleep
   task automatic t_side();
      @(posedge ref_clk);
      adc_sample <= 14'h2ABC;
      adc_sample_valid <= 1'b1;
      comm_fault <= 1'b1;
      repeat (2) @(posedge ref_clk);
      #1 check(16'(adc_result), 16'h2ABC, "raw adc");
      check(16'(unprompted_fault), 16'h0001, "unprompted");
      adc_sample_valid <= 1'b0;
      comm_fault <= 1'b0;
   endtask : t_side
   task automatic t_bal_flt();
      @(posedge ref_clk);
      bal_mode_sel <= BMP_BAL_AUTO;
      bal_target_met <= 1'b0;
      fault_raw <= 1'b1;
      @(posedge ref_clk);
      fault_raw <= 1'b0;
      repeat (4) @(posedge ref_clk);
      #1 check(16'(balance_on), 16'h0001, "auto balancing");
      check(16'(fault_filtered), 16'h0000, "glitch filtered");
      @(posedge ref_clk);
      bal_target_met <= 1'b1;
      fault_raw <= 1'b1;
      repeat (4) @(posedge ref_clk);
      #1 check(16'(balance_on), 16'h0000, "auto stop");
      check(16'(fault_filtered), 16'h0001, "fault held");
      @(posedge ref_clk);
      bal_mode_sel <= 2'h3;
      bal_target_met <= 1'b0;
      fault_raw <= 1'b0;
      repeat (4) @(posedge ref_clk);
      #1 check(16'(balance_on), 16'h0000, "balance off");
      check(16'(fault_filtered), 16'h0000, "fault cleared");
      @(posedge ref_clk);
      bal_mode_sel <= BMP_BAL_MANUAL;
   endtask : t_bal_flt
   task automatic t_recover();
      logic [15:0] exp_sig;
      logic [15:0] next_word;
      exp_sig = BMP_SUM_RST;
      next_word = 16'h0000;
      bmp_host_model_inst.power(1'b0);
      repeat (2) @(posedge ref_clk);
      #1 check(16'(mode), 16'(BMP_OFF), "shutdown");
      check(16'(balance_on), 16'h0000, "no balance when off");
      bmp_host_model_inst.recover();
      for (int i = 0; i < BMP_WORDS; i++) begin
         next_word = next_word + 16'h1357;
         exp_sig = {exp_sig[14:0], exp_sig[15] ^ exp_sig[13]} ^ next_word;
         eeprom_word <= next_word;
         @(posedge ref_clk);
      end
      #1 check(16'(recall_done), 16'h0001, "recall");
      check(eeprom_signature, exp_sig, "signature");
      bmp_host_model_inst.power(1'b0);
      bmp_host_model_inst.power(1'b1);
      repeat (2) @(posedge ref_clk);
      #1 check(eeprom_signature, exp_sig, "no reload");
      t_sum();
   endtask : t_recover
   initial begin
      rst = 1'b1;
      eeprom_word = 16'h0000;
      reg_sum_live = 16'h0000;
      adc_sample = 14'h0000;
      adc_sample_valid = 1'b0;
      comm_fault = 1'b0;
      fault_raw = 1'b0;
      bal_target_met = 1'b0;
      bal_mode_sel = BMP_BAL_MANUAL;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      #1 check(16'(mode), 16'(BMP_OFF), "off at reset");
      bmp_host_model_inst.power(1'b1);
      repeat (2) @(posedge ref_clk);
      #1 check(16'(mode), 16'(BMP_STANDBY), "standby");
      check(16'(BMP_CELLS * BMP_MAX_DEVICES), 16'h00A8, "chain cells");
      t_scan(BMP_CMD_SCAN_A, 2'h0);
      t_scan(BMP_CMD_SCAN_B, 2'h1);
      t_scan(BMP_CMD_DIRECT, 2'h2);
      t_sum();
      t_sleep();
      t_side();
      t_bal_flt();
      t_recover();
      repeat (BMP_WD_CYC + 10) @(posedge ref_clk);
      #1 check(16'(mode), 16'(BMP_SLEEP), "watchdog");
      stop_test();
   end
endmodule : bmp_power_modes_bench
